// ==== hw/pms_pkg.sv ====
package pms_pkg;

	localparam int NUM_SLICES = 8;
	localparam int NUM_PINS   = 8;
	localparam int CODE_W     = 3;
	localparam int SRC_W      = 3;

	// Byte addresses of the registers
	localparam logic [31:0] CTRL_ADDR   = 32'ha000_4028;
	localparam logic [31:0] SRC_ADDR    = 32'ha000_402c;
	localparam logic [31:0] CFG_ADDR    = 32'ha000_4030;
	localparam logic [31:0] STATUS_ADDR = 32'ha000_4034;
	localparam logic [31:0] MASK_ADDR   = 32'ha000_4038;

	// Configuration register layout
	localparam int CFG_EP_LSB   = 0;
	localparam int CFG_EP_W     = 7;
	localparam int CFG_CODE_LSB = 8;
	localparam logic [31:0] CFG_WMASK = 32'hffff_ff7f;

	// Source-select register layout
	localparam int SRC_LSB = 8;
	localparam logic [31:0] SRC_WMASK = 32'hffff_ff00;

	// Control register layout
	localparam int CTRL_SEL_BIT  = 0;
	localparam int CTRL_RXEV_BIT = 1;
	localparam logic [31:0] CTRL_WMASK = 32'h0000_0003;

	// Reset values
	localparam logic [31:0] CFG_RESET    = 32'h0000_0000;
	localparam logic [31:0] SRC_RESET    = 32'h0000_0000;
	localparam logic [31:0] CTRL_RESET   = 32'h0000_0000;
	localparam logic [7:0]  STATUS_RESET = 8'h00;
	localparam logic [7:0]  MASK_RESET   = 8'h00;

	// Contribution-condition codes
	localparam logic [2:0] COND_HIGH      = 3'h0;
	localparam logic [2:0] COND_STK_RISE  = 3'h1;
	localparam logic [2:0] COND_STK_FALL  = 3'h2;
	localparam logic [2:0] COND_STK_EDGE  = 3'h3;
	localparam logic [2:0] COND_LVL_HIGH  = 3'h4;
	localparam logic [2:0] COND_LVL_LOW   = 3'h5;
	localparam logic [2:0] COND_ZERO      = 3'h6;
	localparam logic [2:0] COND_EVENT     = 3'h7;

endpackage

// ==== hw/pms_sync.sv ====
`timescale 1ns/1ps

module pms_sync
(
	input  wire logic                          clk,
	input  wire logic                          rstn,
	input  wire logic [pms_pkg::NUM_PINS-1:0] pinAsync,
	output logic      [pms_pkg::NUM_PINS-1:0] pinSync
);

	genvar g;
	generate
		for (g = 0; g < pms_pkg::NUM_PINS; g = g + 1)
		begin : gBit
			logic stage1;
			always_ff @(posedge clk)
			begin
				if (!rstn)
				begin
					stage1     <= 1'b0;
					pinSync[g] <= 1'b0;
				end
				else
				begin
					stage1     <= pinAsync[g];
					pinSync[g] <= stage1;
				end
			end
		end
	endgenerate

endmodule // pms_sync

// ==== hw/pms_slice.sv ====
`timescale 1ns/1ps

module pms_slice
(
	input  wire logic        clk,
	input  wire logic        rstn,
	input  wire logic        pinLevel,
	input  wire logic [2:0]  code,
	input  wire logic        clearHistory,
	output logic             contribute
);

	logic prevLevel;
	logic primed;
	logic stickyRise;
	logic stickyFall;
	wire  riseNow = primed & pinLevel & ~prevLevel;
	wire  fallNow = primed & ~pinLevel & prevLevel;

	// First sample after reset only primes history, so no false edge
	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			prevLevel <= 1'b0;
			primed    <= 1'b0;
		end
		else
		begin
			prevLevel <= pinLevel;
			primed    <= 1'b1;
		end
	end

	// Edge in the clearing cycle still counts
	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			stickyRise <= 1'b0;
			stickyFall <= 1'b0;
		end
		else
		begin
			stickyRise <= riseNow | (stickyRise & ~clearHistory);
			stickyFall <= fallNow | (stickyFall & ~clearHistory);
		end
	end

	always_comb
	begin
		contribute = 1'b0;
		case (code)
			pms_pkg::COND_HIGH:     contribute = 1'b1;
			pms_pkg::COND_STK_RISE: contribute = stickyRise | riseNow;
			pms_pkg::COND_STK_FALL: contribute = stickyFall | fallNow;
			pms_pkg::COND_STK_EDGE:
				contribute = stickyRise | stickyFall | riseNow | fallNow;
			pms_pkg::COND_LVL_HIGH: contribute = pinLevel;
			pms_pkg::COND_LVL_LOW:  contribute = ~pinLevel;
			pms_pkg::COND_ZERO:     contribute = 1'b0;
			pms_pkg::COND_EVENT:    contribute = riseNow | fallNow;
			default:                contribute = 1'b0;
		endcase
	end

endmodule // pms_slice

// ==== hw/pms_engine.sv ====
`timescale 1ns/1ps

module pms_engine
(
	input  wire logic        clk,
	input  wire logic        rstn,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [31:0] wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic [7:0]  pinIn,
	output logic      [7:0]  matchIrq,
	output logic             rxEvent,
	output logic             irq
);

	localparam int NS = pms_pkg::NUM_SLICES;

	logic [31:0]   sliceConditionConfig;
	logic [31:0]   sliceSourceSelect;
	logic [31:0]   matchControlReg;
	logic [NS-1:0] irqStatus;
	logic [NS-1:0] irqMask;

	logic [7:0]    pinSync;
	logic [NS-1:0] contrib;
	logic [NS-1:0] termAnd;
	logic [NS-1:0] termEnd;
	logic [NS-1:0] rawMatch;

	// Bus decode
	wire        access    = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	wire        wrAccess  = access & wb_we_i;
	wire        rdAccess  = access & ~wb_we_i;
	wire        hitCtrl   = (wb_adr_i == pms_pkg::CTRL_ADDR);
	wire        hitSrc    = (wb_adr_i == pms_pkg::SRC_ADDR);
	wire        hitCfg    = (wb_adr_i == pms_pkg::CFG_ADDR);
	wire        hitStatus = (wb_adr_i == pms_pkg::STATUS_ADDR);
	wire        hitMask   = (wb_adr_i == pms_pkg::MASK_ADDR);
	wire [31:0] byteMask  = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
	                         {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

	wire wrCtrl   = wrAccess & hitCtrl;
	wire wrSrc    = wrAccess & hitSrc;
	wire wrCfg    = wrAccess & hitCfg;
	wire wrMask   = wrAccess & hitMask;
	wire rdStatus = rdAccess & hitStatus;

	wire [31:0] next_cfg = ((sliceConditionConfig & ~byteMask)
	                       | (wb_dat_i & byteMask))
	                       & pms_pkg::CFG_WMASK;
	wire [31:0] next_src = ((sliceSourceSelect & ~byteMask)
	                       | (wb_dat_i & byteMask))
	                       & pms_pkg::SRC_WMASK;
	wire [31:0] next_ctrl = ((matchControlReg & ~byteMask)
	                        | (wb_dat_i & byteMask))
	                        & pms_pkg::CTRL_WMASK;
	wire [NS-1:0] next_mask = wb_sel_i[0] ? wb_dat_i[NS-1:0] : irqMask;

	wire engineSelect = matchControlReg[pms_pkg::CTRL_SEL_BIT];
	wire rxEvEnable   = matchControlReg[pms_pkg::CTRL_RXEV_BIT];

	// Any write to either register clears history, whatever the lanes
	wire clearHistory = wrCfg | wrSrc
	                    | (~engineSelect & ~rxEvEnable);

	wire [31:0] rdData =
		hitCtrl   ? matchControlReg :
		hitSrc    ? sliceSourceSelect :
		hitCfg    ? sliceConditionConfig :
		hitStatus ? {24'h00_0000, irqStatus} :
		hitMask   ? {24'h00_0000, irqMask} :
		32'h0000_0000;

	// Register file
	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			sliceConditionConfig <= pms_pkg::CFG_RESET;
			sliceSourceSelect    <= pms_pkg::SRC_RESET;
			matchControlReg      <= pms_pkg::CTRL_RESET;
			irqMask              <= pms_pkg::MASK_RESET;
		end
		else
		begin
			if (wrCfg)
				sliceConditionConfig <= next_cfg;
			if (wrSrc)
				sliceSourceSelect <= next_src;
			if (wrCtrl)
				matchControlReg <= next_ctrl;
			if (wrMask)
				irqMask <= next_mask;
		end
	end

	// Single-cycle answer; unmapped reads return zero, writes dropped
	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end
		else
		begin
			wb_ack_o <= access;
			if (rdAccess)
				wb_dat_o <= rdData;
		end
	end

	pms_sync uSync
	(
		.clk      (clk),
		.rstn     (rstn),
		.pinAsync (pinIn),
		.pinSync  (pinSync)
	);

	genvar g;
	generate
		for (g = 0; g < NS; g = g + 1)
		begin : gSlice
			wire [2:0] srcSel =
				sliceSourceSelect[pms_pkg::SRC_LSB + 3*g +: 3];
			wire [2:0] condCode =
				sliceConditionConfig[pms_pkg::CFG_CODE_LSB + 3*g +: 3];
			wire selPin = pinSync[srcSel];

			pms_slice uSlice
			(
				.clk          (clk),
				.rstn         (rstn),
				.pinLevel     (selPin),
				.code         (condCode),
				.clearHistory (clearHistory),
				.contribute   (contrib[g])
			);

			if (g == NS - 1)
			begin : gLast
				assign termEnd[g] = 1'b1;
			end
			else
			begin : gFlag
				assign termEnd[g] =
					sliceConditionConfig[pms_pkg::CFG_EP_LSB + g];
			end

			// A slice after an endpoint opens a fresh term
			if (g == 0)
			begin : gFirst
				assign termAnd[g] = contrib[g];
			end
			else
			begin : gChain
				assign termAnd[g] = contrib[g]
				                    & (termEnd[g-1] | termAnd[g-1]);
			end

			assign rawMatch[g] = termEnd[g] & termAnd[g];
		end
	endgenerate

	wire [NS-1:0] request  = rawMatch & {NS{engineSelect}};
	wire          anyMatch = |rawMatch;

	// Status set wins over the read that clears it
	always_ff @(posedge clk)
	begin
		if (!rstn)
			irqStatus <= pms_pkg::STATUS_RESET;
		else if (rdStatus)
			irqStatus <= request;
		else
			irqStatus <= irqStatus | request;
	end

	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			matchIrq <= 8'h00;
			rxEvent  <= 1'b0;
			irq      <= 1'b0;
		end
		else
		begin
			matchIrq <= request;
			rxEvent  <= anyMatch & rxEvEnable;
			irq      <= |((irqStatus | request) & irqMask);
		end
	end

endmodule // pms_engine

// ==== verif/pms_checker.sv ====
`timescale 1ns/1ps
module pms_checker
(
	input wire logic        clk,
	input wire logic        rstn,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [31:0] wb_adr_i,
	input wire logic [3:0]  wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	input wire logic [7:0]  pinIn,
	input wire logic [7:0]  matchIrq,
	input wire logic        rxEvent,
	input wire logic        irq
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	wire req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	wire rdReq = req && !wb_we_i;
	wire rdCfg = rdReq && wb_adr_i == pms_pkg::CFG_ADDR;
	// Every address off the five registers, gaps in the page too
	wire rdOff = rdReq && wb_adr_i != pms_pkg::CTRL_ADDR
		&& wb_adr_i != pms_pkg::SRC_ADDR
		&& wb_adr_i != pms_pkg::CFG_ADDR
		&& wb_adr_i != pms_pkg::STATUS_ADDR
		&& wb_adr_i != pms_pkg::MASK_ADDR;
	a_ack_answer: assert property (req |=> wb_ack_o)
		else $error("ack missing after request");
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	a_no_spurious_ack: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
		else $error("ack without request");
	a_reset_quiet: assert property ($rose(rstn) |-> matchIrq == 8'h0 &&
		!irq && !rxEvent && !wb_ack_o)
		else $error("outputs not cleared by reset");
	a_rsvd_bit7: assert property (wb_ack_o && $past(rdCfg) |-> !wb_dat_o[7])
		else $error("reserved config bit reads one");
	a_unmapped_zero: assert property (wb_ack_o && $past(rdOff) |->
		wb_dat_o == 32'h0000_0000)
		else $error("unmapped read not zero");
	a_dat_hold: assert property ($past(rstn) && !$past(rdReq) |->
		$stable(wb_dat_o))
		else $error("read data changed without read");
	a_match_steady: assert property (($stable(pinIn) && !wb_stb_i)[*6] |->
		$stable(matchIrq))
		else $error("request moved with quiet pins and bus");
	cover property ($rose(matchIrq[0]));
	cover property ($rose(irq));
	cover property (rdCfg);
endmodule // pms_checker

bind pms_engine pms_checker chk (.*);

// ==== verif/pms_pin_model.sv ====
`timescale 1ns/1ps
module pms_pin_model
(
	input  wire logic       clk,
	input  wire logic [7:0] level,
	output logic      [7:0] pins = 8'h0
);
	// Pins move one edge after the request, never mid-cycle
	always @(posedge clk)
		pins <= level;
endmodule // pms_pin_model

// ==== verif/tb.sv ====
`timescale 1ns/1ps
module tb;
	localparam logic [7:0] LOW = 8'h21;
	localparam logic [7:0] UPR = 8'h9a;
	localparam logic [7:0] UPL = 8'h1b;
	localparam logic [7:0] DNR = 8'ha4;
	localparam logic [7:0] DNL = 8'h2f;
	logic        clk = 1'b0, rstn = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
	logic        ack, rxEv, irq;
	logic [31:0] adr = 32'h0, wdat = 32'h0, dout, rd;
	logic [7:0]  lvl = 8'h0, pins, mIrq;
	int          numErrors = 0, comparisons = 0, ticks = 0, r, h;
	pms_pin_model pm (.clk(clk), .level(lvl), .pins(pins));
	pms_engine dut (.clk(clk), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat),
		.wb_dat_o(dout), .wb_ack_o(ack), .pinIn(pins), .matchIrq(mIrq),
		.rxEvent(rxEv), .irq(irq));
	always #50 clk = ~clk;
	always @(posedge clk)
	begin
		ticks++;
		if (ticks == 4000)
		begin
			numErrors++;
			printVerdict();
		end
	end
	task automatic printVerdict();
		$display("errors %0d comparisons %0d", numErrors, comparisons);
		if (numErrors == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, s);
		comparisons++;
		if (s !== e)
		begin
			numErrors++;
			$display("[ERR] %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic bx(input logic w, input logic [31:0] a, d);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		@(posedge clk);
		while (ack !== 1'b1)
			@(posedge clk);
		rd = dout;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk);
	endtask
	task automatic waitClk(input int n);
		repeat (n) @(posedge clk);
	endtask
	// Counts rises and high cycles over ten clocks so sync latency does not matter
	task automatic phase(input logic v);
		logic p;
		p = mIrq[0];
		r = 0;
		h = 0;
		lvl <= {7'h0, v};
		repeat (10)
		begin
			@(posedge clk);
			r += int'(mIrq[0] === 1'b1 && p === 1'b0);
			h += int'(mIrq[0] === 1'b1);
			p = mIrq[0];
		end
	endtask
	initial
	begin
		waitClk(5);
		rstn <= 1'b1;
		waitClk(1);
		for (int i = 0; i < 7; i++)
		begin
			bx(1'b0, pms_pkg::CTRL_ADDR + 32'(4 * i), 32'h0);
			chk("reset", 32'h0, rd);
		end
		bx(1'b1, pms_pkg::CFG_ADDR, 32'hffff_ffff);
		bx(1'b0, pms_pkg::CFG_ADDR, 32'h0);
		chk("cfg", 32'hffff_ff7f, rd);
		bx(1'b1, pms_pkg::CTRL_ADDR, 32'h1);
		for (int c = 0; c < 8; c++)
		begin
			bx(1'b1, pms_pkg::CFG_ADDR, 32'(c) << 8 | 32'h1);
			waitClk(5);
			chk("low", 32'(LOW[c]), 32'(mIrq[0]));
			phase(1'b1);
			chk("upEdges", 32'(UPR[c]), 32'(r));
			chk("upLevel", 32'(UPL[c]), 32'(mIrq[0]));
			if (c == 7)
				chk("pulse", 32'h1, 32'(h));
			phase(1'b0);
			chk("dnEdges", 32'(DNR[c]), 32'(r));
			chk("dnLevel", 32'(DNL[c]), 32'(mIrq[0]));
			bx(1'b1, pms_pkg::SRC_ADDR, 32'h0);
			waitClk(5);
			chk("cleared", 32'(LOW[c]), 32'(mIrq[0]));
		end
		bx(1'b1, pms_pkg::CFG_ADDR, 32'h0000_0101);
		phase(1'b1);
		bx(1'b1, pms_pkg::CTRL_ADDR, 32'h2);
		waitClk(5);
		chk("rxEvent", 32'h1, 32'(rxEv));
		bx(1'b1, pms_pkg::CTRL_ADDR, 32'h0);
		bx(1'b1, pms_pkg::CTRL_ADDR, 32'h1);
		waitClk(5);
		chk("disabled", 32'h0, 32'(mIrq[0]));
		bx(1'b1, pms_pkg::CFG_ADDR, 32'h0000_2402);
		bx(1'b1, pms_pkg::SRC_ADDR, 32'h0000_0800);
		bx(1'b0, pms_pkg::STATUS_ADDR, 32'h0);
		for (int v = 0; v < 4; v++)
		begin
			lvl <= 8'(v);
			waitClk(6);
			chk("terms", v == 3 ? 32'h82 : 32'h80, 32'(mIrq));
		end
		lvl <= 8'h0;
		bx(1'b1, pms_pkg::MASK_ADDR, 32'h2);
		waitClk(3);
		chk("irqOn", 32'h1, 32'(irq));
		bx(1'b0, pms_pkg::STATUS_ADDR, 32'h0);
		chk("status", 32'h82, rd);
		bx(1'b0, pms_pkg::STATUS_ADDR, 32'h0);
		chk("statusClr", 32'h80, rd);
		waitClk(3);
		chk("irqMasked", 32'h0, 32'(irq));
		printVerdict();
	end
endmodule // tb
